// >>> acpc_div_if.sv
`timescale 1ns/1ps
interface acpc_div_if;
  logic src;
  logic powered;
  logic [6:0] code;
  logic clk_out;
  modport ctl(output src, output powered, output code, input clk_out);
  modport div(input src, input powered, input code, output clk_out);
endinterface

// >>> acpc_divider.sv
`timescale 1ns/1ps
module acpc_divider (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  acpc_div_if.div port
);
  typedef struct packed {
    logic src;
    logic [6:0] cnt;
    logic out;
  } acpc_div_state_t;

  acpc_div_state_t q, d;
  logic [7:0] ratio;

  // Code zero divides by the largest ratio
  assign ratio = (port.code == 7'h00) ? acpc_pkg::DIV_ZERO : {1'b0, port.code};

  // Count source rising edges, output high for the first half
  always_comb begin
    d = q;
    d.src = port.src;
    if (!port.powered) begin
      d.cnt = '0;
      d.out = 1'b0;
    end else begin
      if (port.src && !q.src) begin
        d.cnt = (({1'b0, q.cnt} + 8'h01) >= ratio) ? 7'h00 : q.cnt + 7'h01;
      end else if ({1'b0, q.cnt} >= ratio) begin
        d.cnt = 7'h00; // Code cut below the count restarts it
      end
      d.out = (ratio == 8'h01) ? port.src : ({1'b0, d.cnt} < (ratio >> 1));
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign port.clk_out = q.out;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  chk_div_parked_low: assert property (i_clk_en && !port.powered |=> !port.clk_out)
    else $error("divider output moved while powered down");
  chk_div_count_range: assert property (i_clk_en && port.powered |=> {1'b0, q.cnt} < $past(ratio))
    else $error("divider count beyond ratio");
  cov_div_wrap: cover property (port.powered && q.cnt != 7'h00 ##1 q.cnt == 7'h00);
endmodule

// >>> acpc_host_model.sv
`timescale 1ns/1ps
module acpc_host_model (
  input wire logic i_clock,
  output logic o_bclk,
  output logic o_wclk,
  output logic o_din
);
  initial begin
    o_bclk = 1'b0;
    o_wclk = 1'b0;
    o_din = 1'b0;
  end
  // One mono frame; bit clock stands still outside it
  task automatic send(input logic [1:0] fmt, input int bits, input int ofs, input logic inv,
      input logic [31:0] data);
    int first;
    int last;
    int k;
    first = (fmt == 2'h0) ? ofs + 2 : ofs + 1;
    if (fmt == 2'h2) first = 1;
    last = first + bits;
    for (k = 0; k < last + 2; k++) begin
      @(posedge i_clock);
      #1;
      o_bclk = inv;
      case (fmt)
        2'h0: o_wclk = (k == 0);
        2'h1: o_wclk = (k == 1);
        2'h2: o_wclk = (k < last);
        default: o_wclk = (k >= 1);
      endcase
      // MSB first inside the slot, toggling pattern elsewhere
      if (k >= first && k < last) o_din = data[last - 1 - k];
      else o_din = ~o_din;
      repeat (4) @(posedge i_clock);
      #1;
      o_bclk = ~inv;
      repeat (3) @(posedge i_clock);
    end
    @(posedge i_clock);
    #1;
    o_bclk = inv;
    o_din = ~o_din;
  endtask
endmodule

// >>> acpc_pkg.sv
package acpc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_INSTR = 8'h0f;
  localparam logic [7:0] ADDR_INTERP = 8'h10;
  localparam logic [7:0] ADDR_RSVD_FIRST = 8'h11;
  localparam logic [7:0] ADDR_RSVD_LAST = 8'h18;
  localparam logic [7:0] ADDR_CLOCK_OUTPUT_PIN_SRC = 8'h19;
  localparam logic [7:0] ADDR_CLOCK_OUTPUT_PIN_DIV = 8'h1a;
  localparam logic [7:0] ADDR_PORT_CTL = 8'h1b;
  localparam logic [7:0] ADDR_SLOT_OFS = 8'h1c;
  localparam logic [7:0] ADDR_PORT_CTL2 = 8'h1d;

  // Reset values
  localparam logic [7:0] RST_INSTR = 8'h80;
  localparam logic [3:0] RST_INTERP = 4'h8;
  localparam logic [7:0] RST_CLOCK_OUTPUT_PIN_DIV = 8'h01;

  // Decoded values for code zero
  localparam logic [10:0] INSTR_ZERO_COUNT = 11'h400;
  localparam logic [4:0] RATIO_ZERO = 5'h10;
  localparam logic [7:0] DIV_ZERO = 8'h80;

  // Audio format codes
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_DSP = 2'h1;
  localparam logic [1:0] FMT_RIGHT_JUSTIFIED = 2'h2;
  localparam logic [1:0] FMT_LEFT_JUSTIFIED = 2'h3;
  localparam logic [8:0] I2S_BIT_DELAY = 9'h001;

  // Word length codes and bit counts
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [5:0] BITS_16 = 6'h10;
  localparam logic [5:0] BITS_20 = 6'h14;
  localparam logic [5:0] BITS_24 = 6'h18;
  localparam logic [5:0] BITS_32 = 6'h20;

  // Clock output divider source codes
  localparam logic [2:0] SRC_MCLK = 3'h0;
  localparam logic [2:0] SRC_BCLK = 3'h1;
  localparam logic [2:0] SRC_DIN = 3'h2;
  localparam logic [2:0] SRC_PLL = 3'h3;
  localparam logic [2:0] SRC_DAC_DSP = 3'h4;
  localparam logic [2:0] SRC_DAC_MOD = 3'h5;

  // Bit clock divider source codes
  localparam logic [1:0] BSRC_DAC_DSP = 2'h0;
  localparam logic [1:0] BSRC_DAC_MOD = 2'h1;

  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef struct packed {
    logic power;
    logic [6:0] m_code;
  } acpc_div_reg_t;

  typedef struct packed {
    logic [1:0] fmt;
    logic [1:0] wlen;
    logic bclk_out;
    logic wclk_out;
    logic [1:0] rsvd;
  } acpc_port_ctl_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic invert;
    logic keep_active;
    logic [1:0] bit_clock_divider_source;
  } acpc_ctl2_t;
endpackage

// >>> acpc_top.sv
`timescale 1ns/1ps
// Summary of operation
// - The instruction count output is four times the register code, with code zero giving 1024.
// - The interpolation ratio equals its 4-bit code, code zero gives 16, and it resets to 8.
// - A 3-bit code picks the clock output divider source, and codes 110 and 111 pick nothing.
// - Bit 7 of the clock output divider register powers the M divider, off after reset.
// - The M divider divides by its 7-bit code, code zero gives 128, and it resets to 1.
// - The format field picks I2S, DSP, right or left justified, and two bits drive the clocks.
// - The word length field picks 16, 20, 24 or 32 bits.
// - The slot offset delays the data by 0 to 255 bit clocks from the word clock edge, 1 to 256 in I2S, and right justified ignores it.
// - The invert bit inverts the bit clock on every bit clock path.
// - The keep bit runs bit clock and word clock while the codec is powered down.
// - The bit clock divider source is the DAC DSP clock or the modulator clock, others reserved.
// - The bit clock source feeds an N divider by its 7-bit code, code zero giving 128.
module acpc_top (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_mclk,
  input wire logic i_pll_clk,
  input wire logic i_dac_dsp_clock,
  input wire logic i_dac_modulator_clock,
  input wire logic i_dac_fs,
  input wire logic i_codec_powered,
  input wire logic i_bclk_n_power,
  input wire logic [6:0] i_bclk_n_code,
  input wire logic i_bclk,
  output logic o_bclk,
  output logic o_bclk_oe_n,
  input wire logic i_wclk,
  output logic o_wclk,
  output logic o_wclk_oe_n,
  input wire logic i_din,
  output logic o_clock_output_pin,
  output logic [10:0] o_dsp_instruction_count,
  output logic [4:0] o_interp_ratio,
  output logic o_audio_valid,
  output logic [31:0] o_audio_word,
  input wire logic i_audio_ready
);
  typedef enum logic [1:0] {RX_IDLE, RX_SKIP, RX_SHIFT} acpc_rx_t;

  typedef struct packed {
    logic [7:0] instr;
    logic [3:0] interp;
    logic [7:0] src_reg;
    acpc_pkg::acpc_div_reg_t mdiv;
    acpc_pkg::acpc_port_ctl_t port;
    logic [7:0] ofs;
    acpc_pkg::acpc_ctl2_t ctl2;
    logic [7:0] rdata;
    logic bclk_o;
    logic wclk_o;
    logic bclk_prev;
    logic wclk_prev;
    acpc_rx_t rx;
    logic [8:0] skip;
    logic [5:0] nbits;
    logic [31:0] sh;
    logic [1:0] cnt;
    logic [31:0] e0;
    logic [31:0] e1;
  } acpc_state_t;

  acpc_state_t q, d;
  logic active, bclk_int, wclk_int, rise, start;
  logic push, accept, pop;
  logic [31:0] pword, mask;
  logic [5:0] wbits;
  logic [32:0] mask_wide;

  acpc_div_if m_if();
  acpc_div_if n_if();

  // Register read mux, reserved and unmapped offsets read zero
  function automatic logic [7:0] reg_read(acpc_state_t s, logic [7:0] a);
    case (a)
      acpc_pkg::ADDR_INSTR: return s.instr;
      acpc_pkg::ADDR_INTERP: return {4'h0, s.interp};
      acpc_pkg::ADDR_CLOCK_OUTPUT_PIN_SRC: return s.src_reg;
      acpc_pkg::ADDR_CLOCK_OUTPUT_PIN_DIV: return s.mdiv;
      acpc_pkg::ADDR_PORT_CTL: return s.port;
      acpc_pkg::ADDR_SLOT_OFS: return s.ofs;
      acpc_pkg::ADDR_PORT_CTL2: return s.ctl2;
      default: return 8'h00;
    endcase
  endfunction

  // Clock output divider source select
  function automatic logic clock_output_pin_pick(logic [2:0] s, logic [5:0] lv);
    case (s)
      acpc_pkg::SRC_MCLK: return lv[0];
      acpc_pkg::SRC_BCLK: return lv[1];
      acpc_pkg::SRC_DIN: return lv[2];
      acpc_pkg::SRC_PLL: return lv[3];
      acpc_pkg::SRC_DAC_DSP: return lv[4];
      acpc_pkg::SRC_DAC_MOD: return lv[5];
      default: return 1'b0;
    endcase
  endfunction

  // Decoded configuration outputs
  assign o_dsp_instruction_count = (q.instr == 8'h00) ? acpc_pkg::INSTR_ZERO_COUNT
                                   : {1'b0, q.instr, 2'b00};
  assign o_interp_ratio = (q.interp == 4'h0) ? acpc_pkg::RATIO_ZERO : {1'b0, q.interp};

  // Clock output M divider
  assign m_if.src = clock_output_pin_pick(q.src_reg[2:0], {i_dac_modulator_clock, i_dac_dsp_clock,
                                i_pll_clk, i_din, i_bclk, i_mclk});
  assign m_if.powered = q.mdiv.power;
  assign m_if.code = q.mdiv.m_code;
  assign o_clock_output_pin = m_if.clk_out;

  // Bit clock N divider, reserved source codes stay still
  assign n_if.src = (q.ctl2.bit_clock_divider_source == acpc_pkg::BSRC_DAC_DSP) ? i_dac_dsp_clock
                  : (q.ctl2.bit_clock_divider_source == acpc_pkg::BSRC_DAC_MOD)
                    ? i_dac_modulator_clock : 1'b0;
  assign n_if.powered = i_bclk_n_power;
  assign n_if.code = i_bclk_n_code;

  acpc_divider u_mdiv (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .port(m_if)
  );

  acpc_divider u_ndiv (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .port(n_if)
  );

  // Port clocks, direction and inversion
  assign active = i_codec_powered || q.ctl2.keep_active;
  assign bclk_int = (q.port.bclk_out ? q.bclk_o : i_bclk) ^ q.ctl2.invert;
  assign wclk_int = q.port.wclk_out ? q.wclk_o : i_wclk;
  assign o_bclk = q.bclk_o;
  assign o_wclk = q.wclk_o;
  assign o_bclk_oe_n = ~q.port.bclk_out;
  assign o_wclk_oe_n = ~q.port.wclk_out;
  assign rise = bclk_int && !q.bclk_prev;

  // Word length decode and data mask
  always_comb begin
    case (q.port.wlen)
      acpc_pkg::WL_16: wbits = acpc_pkg::BITS_16;
      acpc_pkg::WL_20: wbits = acpc_pkg::BITS_20;
      acpc_pkg::WL_24: wbits = acpc_pkg::BITS_24;
      default: wbits = acpc_pkg::BITS_32;
    endcase
    mask_wide = (33'h0_0000_0001 << wbits) - 33'h0_0000_0001;
    mask = mask_wide[31:0];
  end

  // Output buffer handshake
  assign pop = (q.cnt != 2'h0) && i_audio_ready;
  assign accept = push && ((q.cnt != acpc_pkg::BUF_FULL) || pop);
  assign o_audio_valid = q.cnt != 2'h0;
  assign o_audio_word = q.e0;

  // Next state: registers, clocks, receiver and buffer
  always_comb begin
    d = q;
    push = 1'b0;
    pword = '0;
    start = 1'b0;
    if (i_reg_wr) begin
      case (i_reg_addr)
        acpc_pkg::ADDR_INSTR: d.instr = i_reg_wdata;
        acpc_pkg::ADDR_INTERP: d.interp = i_reg_wdata[3:0];
        acpc_pkg::ADDR_CLOCK_OUTPUT_PIN_SRC: d.src_reg = i_reg_wdata;
        acpc_pkg::ADDR_CLOCK_OUTPUT_PIN_DIV: d.mdiv = i_reg_wdata;
        acpc_pkg::ADDR_PORT_CTL: d.port = i_reg_wdata;
        acpc_pkg::ADDR_SLOT_OFS: d.ofs = i_reg_wdata;
        acpc_pkg::ADDR_PORT_CTL2: d.ctl2 = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      d.rdata = reg_read(q, i_reg_addr);
    end
    // Generated clocks driven only while active
    d.bclk_o = active && (n_if.clk_out ^ q.ctl2.invert);
    d.wclk_o = active && i_dac_fs;
    d.bclk_prev = bclk_int;
    if (rise) begin
      d.wclk_prev = wclk_int;
      d.sh = {q.sh[30:0], i_din};
      if (q.port.fmt == acpc_pkg::FMT_RIGHT_JUSTIFIED) begin
        // Word ends at the word clock falling edge
        if (!wclk_int && q.wclk_prev) begin
          push = 1'b1;
          pword = q.sh & mask;
        end
      end else begin
        start = (q.port.fmt == acpc_pkg::FMT_I2S) ? (!wclk_int && q.wclk_prev)
                                                : (wclk_int && !q.wclk_prev);
        if (start) begin
          d.rx = RX_SKIP;
          d.nbits = '0;
          d.skip = {1'b0, q.ofs} + ((q.port.fmt == acpc_pkg::FMT_I2S)
                   ? acpc_pkg::I2S_BIT_DELAY : 9'h000);
        end
        if (d.rx == RX_SKIP) begin
          if (d.skip == 9'h000) begin
            d.rx = RX_SHIFT;
          end else begin
            d.skip = d.skip - 9'h001;
          end
        end
        if (d.rx == RX_SHIFT) begin
          d.nbits = d.nbits + 6'h01;
          if (d.nbits == wbits) begin
            push = 1'b1;
            pword = d.sh & mask;
            d.rx = RX_IDLE;
            d.nbits = '0;
          end
        end
      end
    end
    // Two-entry buffer, head in e0
    if (pop) begin
      d.e0 = q.e1;
      d.cnt = d.cnt - 2'h1;
    end
    if (accept) begin
      if (d.cnt == 2'h0) begin
        d.e0 = pword;
      end else begin
        d.e1 = pword;
      end
      d.cnt = d.cnt + 2'h1;
    end
  end

  // State register with documented reset values
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.instr <= acpc_pkg::RST_INSTR;
      q.interp <= acpc_pkg::RST_INTERP;
      q.mdiv <= acpc_pkg::RST_CLOCK_OUTPUT_PIN_DIV;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  chk_instr_count_decode: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == acpc_pkg::ADDR_INSTR |=>
    o_dsp_instruction_count == (($past(i_reg_wdata) == 8'h00) ? 11'h400
                                : {1'b0, $past(i_reg_wdata), 2'b00}))
    else $error("instruction count decode wrong");
  chk_interp_ratio_decode: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == acpc_pkg::ADDR_INTERP |=>
    o_interp_ratio == (($past(i_reg_wdata[3:0]) == 4'h0) ? 5'h10 : {1'b0, $past(i_reg_wdata[3:0])}))
    else $error("interpolation ratio decode wrong");
  chk_reserved_reads_zero: assert property (
    i_clk_en && i_reg_rd && i_reg_addr >= acpc_pkg::ADDR_RSVD_FIRST
    && i_reg_addr <= acpc_pkg::ADDR_RSVD_LAST |=> o_reg_rdata == 8'h00)
    else $error("reserved register read not zero");
  chk_clock_output_pin_src_reserved: assert property (
    q.src_reg[2:1] == 2'b11 |-> !m_if.src)
    else $error("reserved clock output source not quiet");
  chk_clock_output_pin_powered_off: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == acpc_pkg::ADDR_CLOCK_OUTPUT_PIN_DIV && !i_reg_wdata[7]
    ##1 i_clk_en |=> !o_clock_output_pin)
    else $error("clock output pin not parked after power down");
  chk_pin_static_off: assert property (
    !q.mdiv.power && !$past(q.mdiv.power) && !$past(q.mdiv.power, 2) && $past(i_clk_en, 2)
    |-> $stable(o_clock_output_pin))
    else $error("clock output pin toggled while divider off");
  chk_bclk_direction: assert property (
    i_clk_en && i_reg_wr && i_reg_addr == acpc_pkg::ADDR_PORT_CTL |=>
    o_bclk_oe_n == !$past(i_reg_wdata[3]) && o_wclk_oe_n == !$past(i_reg_wdata[2]))
    else $error("clock pin direction does not follow register");
  chk_bclk_inverted: assert property (
    i_clk_en && active |=> o_bclk == ($past(n_if.clk_out) ^ $past(q.ctl2.invert)))
    else $error("bit clock inversion wrong");
  chk_clocks_parked: assert property (
    i_clk_en && !i_codec_powered && !q.ctl2.keep_active |=> !o_bclk && !o_wclk)
    else $error("port clocks run while codec down without keep");
  chk_bclk_src_reserved: assert property (
    q.ctl2.bit_clock_divider_source[1] |-> !n_if.src)
    else $error("reserved bit clock source not quiet");
  chk_slot_skip_count: assert property (
    i_clk_en && rise && !start && q.rx == RX_SKIP && q.skip != 9'h000
    && q.port.fmt != acpc_pkg::FMT_RIGHT_JUSTIFIED |=> q.skip == $past(q.skip) - 9'h001)
    else $error("slot offset count did not step");
  chk_buffer_holds: assert property (
    i_clk_en && o_audio_valid && !i_audio_ready |=> o_audio_valid && $stable(o_audio_word))
    else $error("buffered word lost under stall");

  cov_word_out: cover property (o_audio_valid && i_audio_ready);
  cov_buffer_full: cover property (q.cnt == acpc_pkg::BUF_FULL);
  cov_dsp_offset: cover property (q.port.fmt == acpc_pkg::FMT_DSP && q.ofs != 8'h00 && push);
  cov_clock_output_pin_toggle: cover property (q.mdiv.power ##1 $rose(o_clock_output_pin));
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_codec_powered = 1'b0;
  logic i_bclk_n_power = 1'b0;
  logic [6:0] i_bclk_n_code = 7'h02;
  logic i_audio_ready = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  logic [7:0] o_reg_rdata;
  logic o_bclk, o_bclk_oe_n, o_wclk, o_wclk_oe_n, o_clock_output_pin, o_audio_valid;
  logic [10:0] o_dsp_instruction_count;
  logic [4:0] o_interp_ratio;
  logic [31:0] o_audio_word;
  logic h_bclk, h_wclk, i_din;
  wire i_mclk = cnt_q[0];
  wire i_pll_clk = cnt_q[1];
  wire i_dac_dsp_clock = cnt_q[1];
  wire i_dac_modulator_clock = cnt_q[2];
  wire i_dac_fs = cnt_q[6];
  wire i_bclk = o_bclk_oe_n ? h_bclk : o_bclk;
  wire i_wclk = o_wclk_oe_n ? h_wclk : o_wclk;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] rv;
  int p;

  acpc_top acpc_top_inst (.i_clock, .i_rst_n, .i_clk_en, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_mclk, .i_pll_clk, .i_dac_dsp_clock,
    .i_dac_modulator_clock, .i_dac_fs, .i_codec_powered, .i_bclk_n_power, .i_bclk_n_code,
    .i_bclk, .o_bclk, .o_bclk_oe_n, .i_wclk, .o_wclk, .o_wclk_oe_n, .i_din,
    .o_clock_output_pin, .o_dsp_instruction_count, .o_interp_ratio, .o_audio_valid,
    .o_audio_word, .i_audio_ready);
  acpc_host_model acpc_host_model_inst (.i_clock, .o_bclk(h_bclk), .o_wclk(h_wclk),
    .o_din(i_din));

  // Clock, source clocks and hang limit
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cnt_q <= #1 cnt_q + 8'h01;
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clock);
    #1;
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1;
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(posedge i_clock);
    #1;
    i_reg_rd = 1'b0;
    @(posedge i_clock);
    #1;
    d = o_reg_rdata;
  endtask
  // Cycles between two rising edges of clock output (sel 0) or bit clock (sel 1), 0 if none
  task automatic period(input bit sel, output int per);
    logic pv;
    logic cv;
    int t0;
    per = 0;
    t0 = -1;
    pv = 1'b1;
    for (int n = 0; n < 2400 && per == 0; n++) begin
      @(posedge i_clock);
      #2;
      cv = sel ? o_bclk : o_clock_output_pin;
      if (cv === 1'b1 && pv === 1'b0) begin
        if (t0 >= 0) per = n - t0;
        else t0 = n;
      end
      pv = cv;
    end
  endtask
  // Waits for a word, compares it and takes it
  task automatic pop(input logic [31:0] exp);
    for (int n = 0; n < 64 && o_audio_valid !== 1'b1; n++) @(posedge i_clock);
    #2;
    chk(o_audio_valid, 1'b1, "valid");
    chk(o_audio_word, exp, "word");
    @(posedge i_clock);
    #1;
    i_audio_ready = 1'b1;
    @(posedge i_clock);
    #1;
    i_audio_ready = 1'b0;
  endtask

  task automatic t_regs();
    logic [7:0] ad[9] = '{8'h0f, 8'h10, 8'h11, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h20};
    logic [7:0] ex[9] = '{8'h80, 8'h08, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ic[4] = '{8'h00, 8'h01, 8'hff, 8'h80};
    logic [10:0] ie[4] = '{11'h400, 11'h004, 11'h3fc, 11'h200};
    logic [3:0] rc[3] = '{4'h0, 4'h1, 4'hf};
    logic [4:0] re[3] = '{5'h10, 5'h01, 5'h0f};
    chk(o_dsp_instruction_count, 11'h200, "count");
    chk(o_interp_ratio, 5'h08, "ratio");
    for (int i = 0; i < 9; i++) begin
      rd(ad[i], rv);
      chk(rv, ex[i], "reset");
    end
    for (int i = 0; i < 4; i++) begin
      wr(acpc_pkg::ADDR_INSTR, ic[i]);
      chk(o_dsp_instruction_count, ie[i], "count");
    end
    for (int i = 0; i < 3; i++) begin
      wr(acpc_pkg::ADDR_INTERP, {4'h0, rc[i]});
      chk(o_interp_ratio, re[i], "ratio");
    end
    wr(acpc_pkg::ADDR_INSTR, 8'h3c);
    chk(o_dsp_instruction_count, 11'h0f0, "count");
    i_clk_en = 1'b0;
    wr(acpc_pkg::ADDR_SLOT_OFS, 8'h5a);
    i_clk_en = 1'b1;
    rd(acpc_pkg::ADDR_SLOT_OFS, rv);
    chk(rv, 8'h00, "frozen");
  endtask

  task automatic t_clock_output_pin();
    logic [2:0] sc[5] = '{3'h0, 3'h3, 3'h5, 3'h4, 3'h6};
    logic [6:0] mc[5] = '{7'h03, 7'h00, 7'h01, 7'h02, 7'h01};
    int pe[5] = '{6, 512, 8, 8, 0};
    wr(8'h1a, 8'h03);
    period(0, p);
    chk(p, 0, "off");
    chk(o_clock_output_pin, 1'b0, "off");
    for (int i = 0; i < 5; i++) begin
      wr(8'h19, {5'h00, sc[i]});
      wr(8'h1a, {1'b1, mc[i]});
      period(0, p);
      chk(p, pe[i], "clock_output_pin");
    end
  endtask

  task automatic t_bclk();
    wr(8'h1b, 8'h0c);
    chk({o_bclk_oe_n, o_wclk_oe_n}, 2'h0, "oe");
    i_bclk_n_power = 1'b1;
    period(1, p);
    chk(p, 0, "down");
    wr(8'h1d, 8'h04);
    period(1, p);
    chk(p, 8, "dsp");
    wr(8'h1d, 8'h05);
    period(1, p);
    chk(p, 16, "mod");
    i_bclk_n_code = 7'h00;
    period(1, p);
    chk(p, 1024, "n128");
    wr(8'h1d, 8'h06);
    period(1, p);
    chk(p, 0, "rsvd");
    i_bclk_n_code = 7'h02;
    i_codec_powered = 1'b1;
    wr(8'h1d, 8'h00);
    period(1, p);
    chk(p, 8, "up");
    wr(8'h1b, 8'h00);
    chk({o_bclk_oe_n, o_wclk_oe_n}, 2'h3, "oe");
  endtask

  task automatic t_stream();
    logic [1:0] fm[5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h1};
    int bt[5] = '{16, 20, 24, 32, 16};
    int of[5] = '{0, 3, 1, 0, 255};
    logic [31:0] dw[5] = '{32'hb4c3, 32'ha5c31, 32'hc39e17, 32'h9d2b71e6, 32'h6e19};
    for (int i = 0; i < 5; i++) begin
      wr(8'h1b, {fm[i], 2'(i % 4), 4'h0});
      wr(8'h1c, 8'(of[i]));
      wr(8'h1d, {4'h0, i == 4, 3'h0});
      acpc_host_model_inst.send(fm[i], bt[i], of[i], i == 4, dw[i]);
      pop(dw[i]);
    end
  endtask

  task automatic t_buffer();
    wr(8'h1b, 8'h40);
    wr(8'h1c, 8'h00);
    wr(8'h1d, 8'h00);
    acpc_host_model_inst.send(2'h1, 16, 0, 1'b0, 32'h1111);
    acpc_host_model_inst.send(2'h1, 16, 0, 1'b0, 32'h2222);
    acpc_host_model_inst.send(2'h1, 16, 0, 1'b0, 32'h3333);
    pop(32'h1111);
    pop(32'h2222);
    chk(o_audio_valid, 1'b0, "drop");
  endtask

  initial begin
    repeat (8) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    t_regs();
    t_clock_output_pin();
    t_bclk();
    t_stream();
    t_buffer();
    end_sim();
  end
endmodule
